// ---- design/nvsram_host_ctrl.sv ----
// host-side controller driving a non-volatile sram through its pins
// assumes an asynchronous 32K x 8 part; busy pin is open drain, pulled up
// Function
// - keep chip select high during power up
// - hold address stable across the write
// - keep output gate high during write
// - avoid write state when power-up recall ends
// - software store: six reads, 0E38 to 0FC0
module nvsram_host_ctrl
    import nvsram_host_pkg::*;
(
    // clock and reset
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    // user command port
    input  wire logic                REQ_VALID,
    input  wire nvsram_host_pkg::cmd_t REQ_CMD,
    input  wire logic [ADDR_W-1:0]   REQ_ADDR,
    input  wire logic [DATA_W-1:0]   REQ_WDATA,
    input  wire logic                HW_STORE_REQ,
    output logic                     REQ_READY,
    output logic                     RSP_VALID,
    output logic [DATA_W-1:0]        RSP_RDATA,
    output logic                     DEV_BUSY,
    // memory pins
    output logic [ADDR_W-1:0]        ADDR_LINES_15,
    output logic                     CHIP_SELECT_N,
    output logic                     OUTPUT_GATE_N,
    output logic                     WRITE_STROBE_N,
    input  wire logic [DATA_W-1:0]   IO_BYTE_LINES_I,
    output logic [DATA_W-1:0]        IO_BYTE_LINES_O,
    output logic                     IO_BYTE_LINES_OE_N,
    input  wire logic                HW_STORE_BUSY_N_I,
    output logic                     HW_STORE_BUSY_N_O,
    output logic                     HW_STORE_BUSY_N_OE_N
);
    import nvsram_host_pkg::*;

    // refuse timings that the cycle counter cannot hold
    if (SETUP_CYC < 1 || ACCESS_CYC < 1 || ACCESS_CYC + 2 >= (1 << CNT_W)
        || HSB_PULSE_CYC >= (1 << CNT_W)) begin : g_bad_timing
        $error("cycle counts do not fit the counter");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_GAP,
        ST_HSB_PULSE,
        ST_HSB_WAIT
    } state_t;

    state_t              state_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [2:0]          seq_idx_q;
    logic                seq_mode_q;
    cmd_t                cmd_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   rdata_s;
    logic                busy_n_s;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    nvsram_pin_sync #(.WIDTH(DATA_W + 1)) u_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     ({IO_BYTE_LINES_I, HW_STORE_BUSY_N_I}),
        .q     ({rdata_s, busy_n_s})
    );

    // address of step idx in a software sequence
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input cmd_t c);
        case (idx)
            3'h0:    seq_addr = SEQ_A0;
            3'h1:    seq_addr = SEQ_A1;
            3'h2:    seq_addr = SEQ_A2;
            3'h3:    seq_addr = SEQ_A3;
            3'h4:    seq_addr = SEQ_A4;
            default: seq_addr = (c == CMD_SW_RECALL) ? SEQ_RECALL : SEQ_STORE;
        endcase
    endfunction

    wire is_write = (cmd_q == CMD_WRITE) && !seq_mode_q;
    wire last_step = (seq_idx_q == 3'(SEQ_LEN - 1));

    // ------------------------------------------------------------
    // cycle state machine
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_q    <= ST_IDLE;
            cnt_q      <= '0;
            seq_idx_q  <= '0;
            seq_mode_q <= 1'b0;
            cmd_q      <= CMD_READ;
            addr_q     <= '0;
            wdata_q    <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // a low busy pin means store, recall or brownout: wait
                    if (HW_STORE_REQ && busy_n_s) begin
                        state_q <= ST_HSB_PULSE;
                        cnt_q   <= CNT_W'(HSB_PULSE_CYC);
                    end else if (REQ_VALID && busy_n_s) begin
                        cmd_q      <= REQ_CMD;
                        wdata_q    <= REQ_WDATA;
                        seq_idx_q  <= '0;
                        seq_mode_q <= (REQ_CMD == CMD_SW_STORE) || (REQ_CMD == CMD_SW_RECALL);
                        addr_q     <= ((REQ_CMD == CMD_SW_STORE) || (REQ_CMD == CMD_SW_RECALL))
                                      ? SEQ_A0 : REQ_ADDR;
                        state_q    <= ST_SETUP;
                        cnt_q      <= CNT_W'(SETUP_CYC);
                    end
                end
                ST_SETUP: begin
                    // address settles with select high before the falling edge
                    if (cnt_q <= 8'h01) begin
                        state_q <= ST_STROBE;
                        cnt_q   <= CNT_W'(ACCESS_CYC + 2);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_STROBE: begin
                    if (cnt_q <= 8'h01) begin
                        state_q <= ST_GAP;
                        cnt_q   <= CNT_W'(SETUP_CYC);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_GAP: begin
                    // select high between sequence reads gives one edge per read
                    if (cnt_q <= 8'h01) begin
                        if (seq_mode_q && !last_step) begin
                            seq_idx_q <= seq_idx_q + 3'h1;
                            addr_q    <= seq_addr(seq_idx_q + 3'h1, cmd_q);
                            state_q   <= ST_SETUP;
                            cnt_q     <= CNT_W'(SETUP_CYC);
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_HSB_PULSE: begin
                    if (cnt_q <= 8'h01) begin
                        state_q <= ST_HSB_WAIT;
                        cnt_q   <= 8'h03;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_HSB_WAIT: begin
                    // released pin stays low while the device stores
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else if (busy_n_s) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            // select parked high from reset onward
            ADDR_LINES_15        <= '0;
            CHIP_SELECT_N        <= 1'b1;
            OUTPUT_GATE_N        <= 1'b1;
            WRITE_STROBE_N       <= 1'b1;
            IO_BYTE_LINES_O      <= '0;
            IO_BYTE_LINES_OE_N   <= 1'b1;
            HW_STORE_BUSY_N_O    <= 1'b0;
            HW_STORE_BUSY_N_OE_N <= 1'b1;
        end else begin
            ADDR_LINES_15        <= addr_q;
            CHIP_SELECT_N        <= (state_q != ST_STROBE);
            // user read: gate low, strobe high; gate high on writes and sequence reads
            OUTPUT_GATE_N        <= !(state_q == ST_STROBE && !is_write && !seq_mode_q);
            WRITE_STROBE_N       <= !(state_q == ST_STROBE && is_write);
            IO_BYTE_LINES_O      <= wdata_q;
            IO_BYTE_LINES_OE_N   <= !(is_write && (state_q == ST_SETUP || state_q == ST_STROBE
                                      || state_q == ST_GAP));
            HW_STORE_BUSY_N_OE_N <= (state_q != ST_HSB_PULSE);
        end
    end

    // ------------------------------------------------------------
    // user answers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= '0;
            DEV_BUSY  <= 1'b1;
        end else begin
            // acknowledge: the request is taken at this edge
            REQ_READY <= (state_q == ST_IDLE) && busy_n_s && REQ_VALID && !HW_STORE_REQ;
            RSP_VALID <= (state_q == ST_STROBE) && (cnt_q == 8'h01) && !seq_mode_q;
            if ((state_q == ST_STROBE) && (cnt_q == 8'h01) && !is_write && !seq_mode_q)
                RSP_RDATA <= rdata_s;
            DEV_BUSY  <= !busy_n_s;
        end
    end
endmodule

// ---- design/nvsram_host_pkg.sv ----
// constants for the host-side controller of a non-volatile sram
// assumes a 100 MHz clock and an asynchronous byte-wide memory on pins
package nvsram_host_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 32768;

    // bus timing in ns and derived cycles (least times round up)
    localparam int CLK_NS = 10;
    localparam int ACCESS_NS = 25;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS = 10;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HSB_PULSE_NS = 50;
    localparam int HSB_PULSE_CYC = (HSB_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;

    // software store and recall sequences
    localparam int SEQ_LEN = 6;
    localparam logic [14:0] SEQ_A0 = 15'h0E38;
    localparam logic [14:0] SEQ_A1 = 15'h31C7;
    localparam logic [14:0] SEQ_A2 = 15'h03E0;
    localparam logic [14:0] SEQ_A3 = 15'h3C1F;
    localparam logic [14:0] SEQ_A4 = 15'h303F;
    localparam logic [14:0] SEQ_STORE = 15'h0FC0;
    localparam logic [14:0] SEQ_RECALL = 15'h0C63;

    // host command codes
    typedef enum logic [1:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_SW_STORE,
        CMD_SW_RECALL
    } cmd_t;

endpackage

// ---- design/nvsram_pin_sync.sv ----
// two-flop synchroniser for pins arriving from the memory
// assumes one clock, asynchronous active-low reset
module nvsram_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // pins
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ---- verification/nvsram_dev_model.sv ----
// behavioural nvsram on the far side of the host controller pins
// assumes the bench resolves the shared data and busy wires
module nvsram_dev_model
    import nvsram_host_pkg::*;
#(
    parameter int STORE_NS  = 150,
    parameter int RECALL_NS = 100
) (
    // memory pins
    input  wire logic [ADDR_W-1:0] a,
    input  wire logic              cs_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    input  wire logic              hsb_i,
    output logic                   hsb_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5*ADDR_W-1:0] PRE = {SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [7:0]          mem [MEM_BYTES];
    logic [7:0]          nv [MEM_BYTES];
    logic [6*ADDR_W-1:0] hist = '0;
    logic                wr_q = 1'b0;
    logic                nvop = 1'b0;
    logic [7:0]          last = 8'h00;
    logic                in_wr = 1'b0;
    logic                in_rd = 1'b0;
    // ----------------------------------------
    // array, store and recall
    // ----------------------------------------
    initial begin
        hsb_pull = 1'b0;
        mem = '{default: 8'hFF};
        nv = '{default: 8'hFF};
        recall();
    end
    task automatic store();
        nvop = 1'b1;
        hsb_pull = 1'b1;
        nv = '{default: 8'hFF};
        #(STORE_NS) nv = mem;
        wr_q = 1'b0;
        hsb_pull = 1'b0;
        nvop = 1'b0;
    endtask
    task automatic recall();
        nvop = 1'b1;
        mem = '{default: 8'h00};
        #(RECALL_NS) mem = nv;
        nvop = 1'b0;
    endtask
    // released lines show the inverse of the last byte
    always @(a or cs_n or oe_n or we_n or hsb_i or nvop) begin
        if (!cs_n && !oe_n && we_n && hsb_i && !nvop) begin
            dq_o = mem[a];
            last = mem[a];
        end else
            dq_o = ~last;
    end
    // note which kind of cycle a low select has opened
    always @(cs_n or we_n) begin
        if (!cs_n && !we_n)
            in_wr = 1'b1;
        else if (!cs_n)
            in_rd = 1'b1;
    end
    always @(posedge we_n or posedge cs_n) begin
        if (in_wr) begin
            in_wr = 1'b0;
            in_rd = 1'b0;
            if (hsb_i && !nvop) begin
                mem[a] = dq_i;
                wr_q = 1'b1;
                hist = '0;
            end
        end else if (in_rd && cs_n) begin
            in_rd = 1'b0;
            if (hsb_i && !nvop) begin
                hist = {hist[5*ADDR_W-1:0], a};
                if (hist == {PRE, SEQ_STORE})
                    store();
                else if (hist == {PRE, SEQ_RECALL})
                    recall();
            end
        end
    end
    always @(negedge hsb_i) begin
        if (!hsb_pull && !nvop && wr_q)
            store();
    end
endmodule

// ---- verification/nvsram_host_ctrl_chk.sv ----
// pin checks for the nvsram host controller
// assumes a bind to nvsram_host_ctrl, one clock domain
module nvsram_host_ctrl_chk
    import nvsram_host_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RST_N,
    input wire logic              RSP_VALID,
    input wire logic              DEV_BUSY,
    input wire logic [ADDR_W-1:0] ADDR_LINES_15,
    input wire logic              CHIP_SELECT_N,
    input wire logic              OUTPUT_GATE_N,
    input wire logic              WRITE_STROBE_N,
    input wire logic              IO_BYTE_LINES_OE_N,
    input wire logic              HW_STORE_BUSY_N_OE_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_pull;
        !HW_STORE_BUSY_N_OE_N [*5] ##1 HW_STORE_BUSY_N_OE_N;
    endsequence
    property p_rd; !CHIP_SELECT_N && !OUTPUT_GATE_N |-> WRITE_STROBE_N; endproperty
    property p_wr; !WRITE_STROBE_N |-> !CHIP_SELECT_N && !IO_BYTE_LINES_OE_N; endproperty
    property p_hold; !WRITE_STROBE_N && $past(!WRITE_STROBE_N) |-> $stable(ADDR_LINES_15); endproperty
    property p_blk; DEV_BUSY [*3] |-> CHIP_SELECT_N; endproperty
    property p_rsp; RSP_VALID |=> !RSP_VALID; endproperty
    property p_pull; $fell(HW_STORE_BUSY_N_OE_N) |-> s_pull; endproperty
    property p_pcs; !HW_STORE_BUSY_N_OE_N |-> CHIP_SELECT_N; endproperty
    property p_drv; !IO_BYTE_LINES_OE_N |-> OUTPUT_GATE_N; endproperty
    a_rd: assert property (p_rd) else $error("read with strobe low");
    a_wr: assert property (p_wr) else $error("write without select");
    a_hold: assert property (p_hold) else $error("address moved in write");
    a_blk: assert property (p_blk) else $error("access while busy");
    a_rsp: assert property (p_rsp) else $error("response too long");
    a_pull: assert property (p_pull) else $error("busy pulse length");
    a_pcs: assert property (p_pcs) else $error("access during pulse");
    a_drv: assert property (p_drv) else $error("data driven, gate low");
endmodule
bind nvsram_host_ctrl nvsram_host_ctrl_chk chk (.CLOCK(CLOCK), .RST_N(RST_N),
    .RSP_VALID(RSP_VALID), .DEV_BUSY(DEV_BUSY), .ADDR_LINES_15(ADDR_LINES_15),
    .CHIP_SELECT_N(CHIP_SELECT_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
    .WRITE_STROBE_N(WRITE_STROBE_N), .IO_BYTE_LINES_OE_N(IO_BYTE_LINES_OE_N),
    .HW_STORE_BUSY_N_OE_N(HW_STORE_BUSY_N_OE_N));

// ---- verification/nvsram_host_ctrl_test.sv ----
// self-checking bench: host controller against a behavioural nvsram
// assumes package, design, device model and checker compiled first
module nvsram_host_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import nvsram_host_pkg::*;
    logic              clock, rst_n, req_valid, hw_store_req, ready, rsp_valid, dev_busy;
    logic              cs_n, oe_n, we_n, dq_oe_n, hsb_o, hsb_oe_n, dev_pull, hw_store_busy_n;
    cmd_t              req_cmd;
    logic [ADDR_W-1:0] req_addr, bus_addr, addr;
    logic [DATA_W-1:0] req_wdata, rdata, dq_o, dev_dq, dq, rd;
    logic [31:0]       seed = 32'h5BD17A9C;
    logic [7:0]        sh [logic [14:0]];
    int                errors = 0, samples_checked = 0, busy_cnt = 0;
    // busy pin pulled up unless either side pulls it low
    assign dq  = dq_oe_n ? dev_dq : dq_o;
    assign hw_store_busy_n = (hsb_oe_n || hsb_o) && !dev_pull;
    nvsram_host_ctrl dut (.CLOCK(clock), .RST_N(rst_n), .REQ_VALID(req_valid),
        .REQ_CMD(req_cmd), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .HW_STORE_REQ(hw_store_req), .REQ_READY(ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rdata), .DEV_BUSY(dev_busy), .ADDR_LINES_15(bus_addr),
        .CHIP_SELECT_N(cs_n), .OUTPUT_GATE_N(oe_n), .WRITE_STROBE_N(we_n),
        .IO_BYTE_LINES_I(dq), .IO_BYTE_LINES_O(dq_o), .IO_BYTE_LINES_OE_N(dq_oe_n),
        .HW_STORE_BUSY_N_I(hw_store_busy_n), .HW_STORE_BUSY_N_O(hsb_o), .HW_STORE_BUSY_N_OE_N(hsb_oe_n));
    nvsram_dev_model dev (.a(bus_addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
        .dq_i(dq), .dq_o(dev_dq), .hsb_i(hw_store_busy_n), .hsb_pull(dev_pull));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_of(logic [14:0] x);
        return sh.exists(x) ? sh[x] : 8'hFF;
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // sequences have no answer: wait out six accesses and the nv operation
    task automatic req(cmd_t c, logic [14:0] x, logic [7:0] d);
        int n;
        n = 0;
        req_cmd <= c;
        req_addr <= x;
        req_wdata <= d;
        req_valid <= 1'b1;
        do @(posedge clock); while (ready !== 1'b1 && ++n < 100);
        req_valid <= 1'b0;
        if (c > CMD_WRITE)
            repeat (80) @(posedge clock);
        else begin
            do @(posedge clock); while (rsp_valid !== 1'b1 && ++n < 100);
        end
        rd = rdata;
        if (n >= 100) errors++;
    endtask
    // a real store keeps the pin low well past the host pulse
    task automatic nv_chk(logic hw, logic long_busy);
        busy_cnt = 0;
        if (hw) begin
            hw_store_req <= 1'b1;
            repeat (4) @(posedge clock);
            hw_store_req <= 1'b0;
            repeat (40) @(posedge clock);
        end else
            req(CMD_SW_STORE, '0, 8'h00);
        chk(8'(busy_cnt > 10), 8'(long_busy));
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rst_n && dev_busy === 1'b1)
            busy_cnt <= busy_cnt + 1;
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        give_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        hw_store_req = 1'b0;
        req_cmd = CMD_READ;
        req_addr = '0;
        req_wdata = '0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (20) @(posedge clock);
        for (int i = 0; i < 12; i++) begin
            addr = i == 0 ? 15'h0000 : i == 1 ? 15'h7FFF : 15'(rnd());
            sh[addr] = 8'(rnd());
            req(CMD_WRITE, addr, sh[addr]);
            req(CMD_READ, addr ^ 15'h0001, 8'h00);
            chk(rd, exp_of(addr ^ 15'h0001));
            req(CMD_READ, addr, 8'h00);
            chk(rd, exp_of(addr));
        end
        addr = 15'h2AAA;
        req(CMD_WRITE, addr, 8'h11);
        nv_chk(1'b0, 1'b1);
        nv_chk(1'b0, 1'b1);
        req(CMD_WRITE, addr, 8'h22);
        req(CMD_SW_RECALL, addr, 8'h00);
        req(CMD_READ, addr, 8'h00);
        chk(rd, 8'h11);
        req(CMD_WRITE, addr, 8'h33);
        nv_chk(1'b1, 1'b1);
        nv_chk(1'b1, 1'b0);
        req(CMD_WRITE, addr, 8'h44);
        req(CMD_SW_RECALL, addr, 8'h00);
        req(CMD_READ, addr, 8'h00);
        chk(rd, 8'h33);
        give_verdict();
    end
endmodule
